// ### wpr_readout.sv
// Region-of-interest readout sequencer with converter and output mux.
// Window settings are latched by the sequencer at frame start and held during a frame.
`timescale 1ns/100ps
`include "wpr_params.svh"

// Overview of operation
// R1: Progressive scan, first selected row to last
// R2: Column positions in steps of eight
// R3: Scan starts at loaded window origin
// R4: Four-pixel horizontal kernel, one per lane
// R5: Lanes at quarter rate, muxed at full
// R6: Frame = overhead plus lines of row+pixels
// R7: Frame overhead from granularity setting
// R8: Row overhead from granularity setting
// R9: Sub-sampling adds eight to row overhead
// R10: Row step one, or two when sub-sampling
// R11: Pixels per line from pixel count
// R12: Lines per frame from line timer
// R13: Vertical only, keep one skip one
// R14: Result appears six converter clocks later
// R15: Ten-bit result per converter sample
// R16: Controller supplies 12.5 ns master clock; the bench drives a 5 ns clock with PIX_DIV of 1
// R17: Reversible scan in X and Y
// R18: Settings stable during a frame
// R19: No valid words during overhead
module wpr_readout
  import wpr_pkg::*;
#(
  parameter int PIX_DIV = 1
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // Control
  input  wire logic        frame_start_i,
  input  wire logic [1:0]  overhead_granularity_i,
  input  wire logic        subsample_en_i,
  input  wire logic        mirror_x_i,
  input  wire logic        mirror_y_i,
  // Window
  input  wire logic [6:0]  col_start_i,
  input  wire logic [8:0]  row_start_i,
  input  wire logic [9:0]  line_pixel_count_i,
  input  wire logic [8:0]  frame_line_timer_i,
  // Pixel array
  input  wire wpr_kernel_t kernel_pixels_i,
  output logic [8:0]       row_addr_o,
  output logic [9:0]       col_addr_o,
  // Pixel stream
  output wpr_word_t        pixel_o,
  output logic             pixel_valid_o,
  output logic             frame_busy_o
);
  wpr_conv_if cif ();

  wpr_state_e  state_reg;
  logic [10:0] cnt_reg;
  logic [9:0]  pix_cnt_reg;
  logic [8:0]  lines_left_reg;
  logic [1:0]  phase_reg;
  logic [7:0]  div_reg;
  logic        pix_en_reg;
  logic        pending_reg;
  logic [1:0]  gran_reg;
  logic        sub_reg;
  logic        mx_reg;
  logic        my_reg;
  logic [9:0]  npix_reg;
  logic [8:0]  nlines_reg;
  logic [9:0]  col_base_reg;
  logic [9:0]  col_ptr_reg;
  logic [8:0]  row_reg;
  logic [9:0]  col_reg;
  logic        adc_tick;
  logic [9:0]  npix_next;
  logic [8:0]  row_step;

  generate
    if (PIX_DIV < 1 || PIX_DIV > 255) begin : g_bad_div
      $error("wpr_readout: PIX_DIV must be 1 to 255");
    end
  endgenerate

  // R7: frame overhead length
  function automatic logic [10:0] fot_len(input logic [1:0] g);
    case (g)
      `WPR_GRAN_3: fot_len = 11'(`WPR_FOT_G3);
      `WPR_GRAN_2: fot_len = 11'(`WPR_FOT_G2);
      `WPR_GRAN_1: fot_len = 11'(`WPR_FOT_G1);
      default:     fot_len = 11'(`WPR_FOT_G0);
    endcase
  endfunction : fot_len

  // R8: row overhead length
  // R9: sub-sampling extension
  function automatic logic [10:0] rot_len(input logic [1:0] g, input logic s);
    logic [10:0] base;
    case (g)
      `WPR_GRAN_3: base = 11'(`WPR_ROT_G3);
      `WPR_GRAN_2: base = 11'(`WPR_ROT_G2);
      `WPR_GRAN_1: base = 11'(`WPR_ROT_G1);
      default:     base = 11'(`WPR_ROT_G0);
    endcase
    rot_len = s ? base + 11'(`WPR_ROT_SUB_EXTRA) : base;
  endfunction : rot_len

  // Master clock enable and converter phase
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg    <= 8'h00;
      pix_en_reg <= 1'b0;
    end else if (div_reg == 8'(PIX_DIV - 1)) begin
      div_reg    <= 8'h00;
      pix_en_reg <= 1'b1;
    end else begin
      div_reg    <= div_reg + 8'h01;
      pix_en_reg <= 1'b0;
    end
  end

  // R5: converter clock is a quarter of pixel rate
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 2'h0;
    end else if (pix_en_reg) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign adc_tick = pix_en_reg && (phase_reg == 2'h3);

  // Start request held until a converter boundary with the sequencer idle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_reg <= 1'b0;
    end else if (frame_start_i) begin
      pending_reg <= 1'b1;
    end else if (adc_tick && state_reg == WPR_IDLE) begin
      pending_reg <= 1'b0;
    end
  end

  // R11: count rounded down to column granularity, counts below eight give eight
  assign npix_next = (line_pixel_count_i[9:3] == 7'h00) ? 10'(`WPR_COL_GRAN)
                                                        : {line_pixel_count_i[9:3], 3'h0};
  // R10: row step per sub-sampling mode
  // R13: keep one row, skip the next
  assign row_step  = sub_reg ? 9'(`WPR_ROW_STEP_SUB) : 9'(`WPR_ROW_STEP_NORMAL);

  // R3: latch window origin and settings at frame start
  // R18: settings sampled once per frame
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gran_reg     <= 2'h0;
      sub_reg      <= 1'b0;
      mx_reg       <= 1'b0;
      my_reg       <= 1'b0;
      npix_reg     <= 10'(`WPR_COL_GRAN);
      nlines_reg   <= 9'h001;
      col_base_reg <= 10'h000;
    end else if (adc_tick && state_reg == WPR_IDLE && pending_reg) begin
      gran_reg     <= overhead_granularity_i;
      sub_reg      <= subsample_en_i;
      mx_reg       <= mirror_x_i;
      my_reg       <= mirror_y_i;
      npix_reg     <= npix_next;
      nlines_reg   <= (frame_line_timer_i == 9'h000) ? 9'h001 : frame_line_timer_i;
      // R2: origin in units of eight columns
      col_base_reg <= {col_start_i, 3'h0};
    end
  end

  // R6: frame overhead, then rows of overhead plus pixels
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg      <= WPR_IDLE;
      cnt_reg        <= 11'h000;
      pix_cnt_reg    <= 10'h000;
      lines_left_reg <= 9'h000;
    end else if (pix_en_reg) begin
      case (state_reg)
        WPR_IDLE: begin
          if (adc_tick && pending_reg) begin
            state_reg      <= WPR_FOT;
            cnt_reg        <= fot_len(overhead_granularity_i) - 11'h001;
            lines_left_reg <= (frame_line_timer_i == 9'h000) ? 9'h000
                                                            : frame_line_timer_i - 9'h001;
          end
        end
        WPR_FOT: begin
          if (cnt_reg == 11'h000) begin
            state_reg <= WPR_ROT;
            cnt_reg   <= rot_len(gran_reg, sub_reg) - 11'h001;
          end else begin
            cnt_reg <= cnt_reg - 11'h001;
          end
        end
        WPR_ROT: begin
          if (cnt_reg == 11'h000) begin
            state_reg   <= WPR_PIX;
            pix_cnt_reg <= npix_reg - 10'h001;
          end else begin
            cnt_reg <= cnt_reg - 11'h001;
          end
        end
        WPR_PIX: begin
          // R12: line count from the line timer
          if (pix_cnt_reg != 10'h000) begin
            pix_cnt_reg <= pix_cnt_reg - 10'h001;
          end else if (lines_left_reg == 9'h000) begin
            state_reg <= WPR_IDLE;
          end else begin
            lines_left_reg <= lines_left_reg - 9'h001;
            state_reg      <= WPR_ROT;
            cnt_reg        <= rot_len(gran_reg, sub_reg) - 11'h001;
          end
        end
        default: state_reg <= WPR_IDLE;
      endcase
    end
  end

  // R1: progressive row advance
  // R17: row direction reversible
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      row_reg <= 9'h000;
    end else if (adc_tick && state_reg == WPR_IDLE && pending_reg) begin
      row_reg <= row_start_i;
    end else if (pix_en_reg && state_reg == WPR_PIX && pix_cnt_reg == 10'h000
                 && lines_left_reg != 9'h000) begin
      row_reg <= my_reg ? row_reg - row_step : row_reg + row_step;
    end
  end

  // R4: kernel of four columns per converter period
  // R17: column direction reversible
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      col_ptr_reg <= 10'h000;
      col_reg     <= 10'h000;
    end else if (pix_en_reg) begin
      if (state_reg == WPR_ROT) begin
        col_ptr_reg <= mx_reg ? col_base_reg + npix_reg - 10'(`WPR_KERNEL) : col_base_reg;
      end else if (state_reg == WPR_PIX && phase_reg == 2'h0) begin
        col_reg     <= col_ptr_reg;
        col_ptr_reg <= mx_reg ? col_ptr_reg - 10'(`WPR_KERNEL)
                              : col_ptr_reg + 10'(`WPR_KERNEL);
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_busy_o <= 1'b0;
    end else begin
      frame_busy_o <= (state_reg != WPR_IDLE) || pending_reg;
    end
  end

  // R19: samples only taken during pixel portion
  assign cif.pix_en    = pix_en_reg;
  assign cif.adc_en    = adc_tick;
  assign cif.sample_en = (state_reg == WPR_PIX);
  assign cif.reverse   = mx_reg;
  assign cif.kernel    = kernel_pixels_i;

  wpr_adc_mux #(.LATENCY(`WPR_ADC_LATENCY)) u_adc_mux (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .cif     (cif)
  );

  assign row_addr_o    = row_reg;
  assign col_addr_o    = col_reg;
  assign pixel_o       = cif.pixel;
  assign pixel_valid_o = cif.pixel_valid;

  // Checking helpers
  wpr_state_e  state_prev;
  logic [10:0] st_ticks;
  logic [8:0]  lines_done;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_prev <= WPR_IDLE;
      st_ticks   <= 11'h000;
      lines_done <= 9'h000;
    end else if (pix_en_reg) begin
      state_prev <= state_reg;
      st_ticks   <= (state_reg != state_prev) ? 11'h001 : st_ticks + 11'h001;
      if (state_reg == WPR_FOT) begin
        lines_done <= 9'h000;
      end else if (state_reg == WPR_PIX && pix_cnt_reg == 10'h000) begin
        lines_done <= lines_done + 9'h001;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  fot_length_a: assert property ( // R7
    $past(state_reg) == WPR_FOT && state_reg == WPR_ROT |->
      st_ticks == fot_len(gran_reg))
    else $error("frame overhead length wrong");
  rot_length_a: assert property ( // R8
    $past(state_reg) == WPR_ROT && state_reg == WPR_PIX |->
      st_ticks == rot_len(gran_reg, sub_reg))
    else $error("row overhead length wrong");
  sub_extend_a: assert property ( // R9
    $past(state_reg) == WPR_ROT && state_reg == WPR_PIX && sub_reg |->
      st_ticks >= 11'(`WPR_ROT_G0 + `WPR_ROT_SUB_EXTRA))
    else $error("sub-sampled row overhead not extended");
  line_pixels_a: assert property ( // R11
    $past(state_reg) == WPR_PIX && state_reg != WPR_PIX |->
      st_ticks == 11'(npix_reg))
    else $error("pixels per line wrong");
  frame_lines_a: assert property ( // R12
    $past(state_reg) == WPR_PIX && state_reg == WPR_IDLE |-> lines_done == nlines_reg)
    else $error("lines per frame wrong");
  row_step_a: assert property ( // R10
    $past(state_reg) == WPR_PIX && state_reg == WPR_ROT |->
      row_reg == (my_reg ? $past(row_reg) - row_step : $past(row_reg) + row_step))
    else $error("row step wrong");
  col_origin_a: assert property ( // R2
    pix_en_reg && state_reg == WPR_PIX && pix_cnt_reg == npix_reg - 10'h001 |=>
      col_reg == (mx_reg ? col_base_reg + npix_reg - 10'(`WPR_KERNEL) : col_base_reg))
    else $error("line does not start at window origin");
  kernel_align_a: assert property ( // R4
    state_reg == WPR_PIX |-> col_reg[1:0] == 2'h0 && col_ptr_reg[1:0] == 2'h0)
    else $error("kernel column not a multiple of four");
  overhead_quiet_a: assert property ( // R19
    adc_tick && state_reg != WPR_PIX |=> !u_adc_mux.pipe_v[0])
    else $error("sample taken during overhead");
  adc_quarter_a: assert property ( // R5
    adc_tick |-> $past(pix_en_reg, PIX_DIV) && $past(phase_reg, PIX_DIV) == 2'h2)
    else $error("converter tick not every fourth pixel");

  generate
    if (PIX_DIV == 1) begin : g_lat_chk
      adc_latency_a: assert property ( // R14
        adc_tick && state_reg == WPR_PIX |-> ##25 pixel_valid_o ##1 pixel_valid_o)
        else $error("converter result delay wrong");
    end
  endgenerate

  full_frame_c: cover property ($past(state_reg) == WPR_PIX && state_reg == WPR_IDLE);
  sub_frame_c:  cover property (state_reg == WPR_ROT && sub_reg && my_reg);
  mirror_x_c:   cover property (pixel_valid_o && mx_reg);
  gran3_c:      cover property (state_reg == WPR_FOT && gran_reg == `WPR_GRAN_3);
endmodule : wpr_readout

// ### wpr_params.svh
// Fixed geometry, encodings and timing counts of the readout sequencer.
// Included by the package; overhead counts are in master clock periods, the converter latency in converter clocks.
`ifndef WPR_PARAMS_SVH
`define WPR_PARAMS_SVH

`define WPR_ARRAY_COLS      640
`define WPR_ARRAY_ROWS      480
`define WPR_COL_GRAN        8
`define WPR_KERNEL          4
`define WPR_ADC_BITS        10
`define WPR_ADC_LATENCY     6
`define WPR_FOT_G3          1200
`define WPR_FOT_G2          624
`define WPR_FOT_G1          336
`define WPR_FOT_G0          192
`define WPR_ROT_G3          48
`define WPR_ROT_G2          32
`define WPR_ROT_G1          24
`define WPR_ROT_G0          20
`define WPR_ROT_SUB_EXTRA   8
`define WPR_ROW_STEP_NORMAL 1
`define WPR_ROW_STEP_SUB    2
`define WPR_GRAN_3          2'h3
`define WPR_GRAN_2          2'h2
`define WPR_GRAN_1          2'h1

`endif

// ### wpr_pkg.sv
// Types shared by the readout sequencer and its converter stage.
// Assumes wpr_params.svh is on the include path.
package wpr_pkg;
  `include "wpr_params.svh"

  typedef enum logic [1:0] {
    WPR_IDLE = 2'b00,
    WPR_FOT  = 2'b01,
    WPR_ROT  = 2'b10,
    WPR_PIX  = 2'b11
  } wpr_state_e;

  typedef logic [`WPR_ADC_BITS-1:0]                   wpr_word_t;
  typedef logic [`WPR_KERNEL-1:0][`WPR_ADC_BITS-1:0]  wpr_kernel_t;
endpackage : wpr_pkg

// ### wpr_conv_if.sv
// Link between the sequencer and the converter/multiplexer stage.
// Both ends run on the one system clock.
`timescale 1ns/100ps
interface wpr_conv_if;
  import wpr_pkg::*;
  logic        pix_en;
  logic        adc_en;
  logic        sample_en;
  logic        reverse;
  wpr_kernel_t kernel;
  wpr_word_t   pixel;
  logic        pixel_valid;

  modport seq  (output pix_en, adc_en, sample_en, reverse, kernel, input pixel, pixel_valid);
  modport conv (input pix_en, adc_en, sample_en, reverse, kernel, output pixel, pixel_valid);
endinterface : wpr_conv_if

// ### wpr_adc_mux.sv
// Four converter lanes with a fixed pipeline delay, then a 4:1 word
// multiplexer onto the pixel bus. Assumes adc_en is every 4th pix_en.
`timescale 1ns/100ps
`include "wpr_params.svh"
module wpr_adc_mux
  import wpr_pkg::*;
#(
  parameter int LATENCY = `WPR_ADC_LATENCY
) (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  // Sequencer side
  wpr_conv_if.conv  cif
);
  wpr_kernel_t           pipe_d [LATENCY];
  logic [LATENCY-1:0]    pipe_v;
  logic [LATENCY-1:0]    pipe_r;
  wpr_kernel_t           hold_reg;
  logic                  hold_rev_reg;
  logic [1:0]            left_reg;
  logic [1:0]            idx_reg;
  wpr_word_t             pixel_reg;
  logic                  valid_reg;

  generate
    if (LATENCY < 1) begin : g_bad_lat
      $error("wpr_adc_mux: LATENCY must be at least 1");
    end
  endgenerate

  // R14: conversion pipeline delay
  // R15: ten-bit word per lane
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pipe_v <= '0;
      pipe_r <= '0;
      for (int i = 0; i < LATENCY; i++) begin
        pipe_d[i] <= '0;
      end
    end else if (cif.adc_en) begin
      pipe_d[0] <= cif.kernel;
      pipe_v[0] <= cif.sample_en;
      pipe_r[0] <= cif.reverse;
      for (int i = 1; i < LATENCY; i++) begin
        pipe_d[i] <= pipe_d[i-1];
        pipe_v[i] <= pipe_v[i-1];
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // R5: four lanes onto one bus
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg     <= '0;
      hold_rev_reg <= 1'b0;
      left_reg     <= 2'h0;
      idx_reg      <= 2'h0;
      pixel_reg    <= '0;
      valid_reg    <= 1'b0;
    end else if (cif.pix_en) begin
      if (cif.adc_en && pipe_v[LATENCY-1]) begin
        hold_reg     <= pipe_d[LATENCY-1];
        hold_rev_reg <= pipe_r[LATENCY-1];
        pixel_reg    <= pipe_d[LATENCY-1][pipe_r[LATENCY-1] ? 3 : 0];
        valid_reg    <= 1'b1;
        left_reg     <= 2'h3;
        idx_reg      <= pipe_r[LATENCY-1] ? 2'h2 : 2'h1;
      end else if (left_reg != 2'h0) begin
        pixel_reg <= hold_reg[idx_reg];
        valid_reg <= 1'b1;
        left_reg  <= left_reg - 2'h1;
        idx_reg   <= hold_rev_reg ? idx_reg - 2'h1 : idx_reg + 2'h1;
      end else begin
        valid_reg <= 1'b0;
      end
    end
  end

  assign cif.pixel       = pixel_reg;
  assign cif.pixel_valid = valid_reg;

  // R5: a kernel leaves as four back-to-back words
  burst_four_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // R5
    (cif.pix_en && cif.adc_en && pipe_v[LATENCY-1]) |=> valid_reg && left_reg == 2'h3)
    else $error("kernel burst did not start with three words pending");
endmodule : wpr_adc_mux

// ### wpr_readout_dummy_never.sv
`timescale 1ns/100ps

// ### wpr_ctrl_model.sv
// Camera controller receive side: records every valid pixel word.
// Assumes one clock shared with the sequencer and no back-pressure.
`timescale 1ns/100ps
module wpr_ctrl_model
  import wpr_pkg::*;
(
  // Clock and reset
  input  wire logic      clock_i,
  input  wire logic      rst_n_i,
  // Pixel stream
  input  wire wpr_word_t pixel_i,
  input  wire logic      pixel_valid_i
);
  int unsigned cyc;
  wpr_word_t   word_q[$];
  int unsigned cyc_q[$];

  // one word per master period, no stall
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
      if (pixel_valid_i === 1'b1) begin
        word_q.push_back(pixel_i);
        cyc_q.push_back(cyc);
      end
    end
  end
endmodule : wpr_ctrl_model

// ### tb_wpr_readout.sv
// Self-checking bench for the window readout sequencer.
// Assumes PIX_DIV of 1 and an array whose words are a function of row and column.
`timescale 1ns/100ps
`include "wpr_params.svh"
module tb_wpr_readout;
  import wpr_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        frame_start_i = 1'b0;
  logic [1:0]  gran = 2'h0;
  logic        sub = 1'b0;
  logic        mx = 1'b0;
  logic        my = 1'b0;
  logic [6:0]  cs = 7'h0;
  logic [8:0]  rs = 9'h0;
  logic [9:0]  np = 10'h8;
  logic [8:0]  nl = 9'h1;
  wpr_kernel_t kp = '0;
  logic [8:0]  row_addr_o;
  logic [9:0]  col_addr_o;
  wpr_word_t   pixel_o;
  logic        pixel_valid_o;
  logic        frame_busy_o;
  int          bad_count = 0;
  int          checked = 0;
  int          seed = 32'hbfd4;

  always #2.5 clock_i = ~clock_i;

  wpr_readout i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .frame_start_i(frame_start_i),
    .overhead_granularity_i(gran), .subsample_en_i(sub), .mirror_x_i(mx), .mirror_y_i(my),
    .col_start_i(cs), .row_start_i(rs), .line_pixel_count_i(np), .frame_line_timer_i(nl),
    .kernel_pixels_i(kp), .row_addr_o(row_addr_o), .col_addr_o(col_addr_o),
    .pixel_o(pixel_o), .pixel_valid_o(pixel_valid_o), .frame_busy_o(frame_busy_o));

  wpr_ctrl_model i_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i), .pixel_i(pixel_o),
    .pixel_valid_i(pixel_valid_o));

  function automatic wpr_word_t pix_val(int r, int c);
    return wpr_word_t'((r * 37 + c * 5) & 32'h3ff);
  endfunction : pix_val

  // Pixel array answer to the addresses
  always @(posedge clock_i) begin
    #1;
    for (int i = 0; i < 4; i++) kp[i] = pix_val(int'(row_addr_o), int'(col_addr_o) + i);
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (exp !== got) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic pulse_start();
    @(posedge clock_i) #1 frame_start_i = 1'b1;
    @(posedge clock_i) #1 frame_start_i = 1'b0;
  endtask : pulse_start

  task automatic run_case(int g, bit s, bit x, bit y);
    int npix, lines, step, frame_overhead_time, row_overhead_time, idx, d, row, col, n;
    npix = 8 * (1 + ($unsigned($random(seed)) % 4));
    lines = 1 + ($unsigned($random(seed)) % 3);
    step = s ? `WPR_ROW_STEP_SUB : `WPR_ROW_STEP_NORMAL;
    frame_overhead_time = (g == 3) ? `WPR_FOT_G3 : (g == 2) ? `WPR_FOT_G2 : (g == 1) ? `WPR_FOT_G1 : `WPR_FOT_G0;
    row_overhead_time = (g == 3) ? `WPR_ROT_G3 : (g == 2) ? `WPR_ROT_G2 : (g == 1) ? `WPR_ROT_G1 : `WPR_ROT_G0;
    if (s) row_overhead_time = row_overhead_time + `WPR_ROT_SUB_EXTRA;
    i_ctrl.word_q.delete();
    i_ctrl.cyc_q.delete();
    @(posedge clock_i) #1;
    gran = g[1:0];
    sub = s;
    mx = x;
    my = y;
    cs = 7'($unsigned($random(seed)) % (81 - npix / 8));
    rs = 9'(8 + $unsigned($random(seed)) % 400);
    np = 10'(npix) | 10'($random(seed) & 7);
    nl = 9'(lines);
    pulse_start();
    // Second request is stored while the first frame runs
    repeat (20) @(posedge clock_i);
    #1;
    chk("busy", 1, frame_busy_o);
    pulse_start();
    n = 0;
    while (frame_busy_o !== 1'b0) begin
      @(posedge clock_i) #1;
      n++;
      if (n > 20000) begin
        bad_count++;
        $display("[FAIL] busy timeout expected 0 seen 1");
        wrap_up();
      end
    end
    repeat (120) @(posedge clock_i);
    chk("word count", 2 * lines * npix, i_ctrl.word_q.size());
    if (i_ctrl.word_q.size() != 2 * lines * npix) return;
    idx = 0;
    for (int f = 0; f < 2; f++) begin
      for (int l = 0; l < lines; l++) begin
        row = y ? int'(rs) - l * step : int'(rs) + l * step;
        for (int k = 0; k < npix; k++) begin
          col = x ? int'(cs) * 8 + npix - 1 - k : int'(cs) * 8 + k;
          chk("pixel", pix_val(row, col), i_ctrl.word_q[idx]);
          if (idx > 0) begin
            d = int'(i_ctrl.cyc_q[idx] - i_ctrl.cyc_q[idx - 1]) - 1;
            if (k > 0) chk("gap in line", 0, d);
            else if (l > 0) chk("row overhead", row_overhead_time, d);
            else chk("frame overhead", 1, d >= frame_overhead_time + row_overhead_time && d <= frame_overhead_time + row_overhead_time + 8);
          end
          idx++;
        end
      end
    end
  endtask : run_case

  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk("valid after reset", 0, pixel_valid_o);
    for (int g = 0; g < 4; g++) run_case(g, g[0], g[0], g[1]);
    run_case(3, 1'b0, 1'b1, 1'b0);
    run_case($unsigned($random(seed)) % 4, 1'($random(seed)), 1'($random(seed)),
             1'($random(seed)));
    wrap_up();
  end
endmodule : tb_wpr_readout
